// File: logic/drc_pkg.sv
`default_nettype none
package drc_pkg;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          MS_PER_S      = 1000;
    // frequency unit is 0.01 Hz
    localparam int          FREQ_W        = 14;
    localparam logic [13:0] FREQ_FULL     = 14'h1388;
    localparam int          SP_W          = 12;
    localparam logic [11:0] SP_FULL       = 12'hfff;
    localparam int          MS_W          = 16;
    localparam int          PER_W         = 20;
    localparam logic [15:0] RAMP_DEF_MS   = 16'h1388;
    localparam logic [13:0] FIXED_DEF     = 14'h05dc;
    localparam int          ADR_W         = 8;
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_ACCEL     = 8'h04;
    localparam logic [7:0]  ADR_DECEL     = 8'h08;
    localparam logic [7:0]  ADR_FIXED     = 8'h0c;
    localparam logic [7:0]  ADR_STATUS    = 8'h10;
    localparam logic [7:0]  ADR_FREQ      = 8'h14;
    localparam logic [7:0]  ADR_TARGET    = 8'h18;
    localparam int          CTRL_SRC_BIT  = 0;
    localparam int          CTRL_MODE_LSB = 4;
    localparam int          CTRL_AER_BIT  = 8;
    localparam logic        SRC_LOCAL     = 1'b0;
    localparam logic [2:0]  MODE_FWD_ONLY = 3'h0;
    localparam logic [2:0]  MODE_BOTH     = 3'h5;
    localparam logic [2:0]  MODE_RST      = 3'h5;
    localparam int          ST_READY_BIT  = 0;
    localparam int          ST_RUN_BIT    = 1;
    localparam int          ST_REV_BIT    = 2;
    localparam int          PIN_N         = 5;
    typedef enum logic [1:0] {
        DRC_STOP = 2'h0,
        DRC_FWD  = 2'h1,
        DRC_REV  = 2'h2
    } drc_state_e;
endpackage : drc_pkg
`default_nettype wire

// File: logic/drc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module drc_sync #(
    parameter int W = drc_pkg::PIN_N
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);
    import drc_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } drc_sync_s;
    drc_sync_s s;
    drc_sync_s next_s;

    always_comb begin
        next_s    = s;
        next_s.s1 = pinIn;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk) begin
        // no reset: pins flush while reset is held, so a level that is
        // already high at release never reaches the edge detect as a rise
        s <= next_s;
    end

    assign pinSync = s.s2;

    property p_sync_pass;
        @(posedge clk) disable iff (!rst_n)
        pinSync == $past(pinIn, 2);
    endproperty
    a_sync_pass: assert property (p_sync_pass) else $error("pin sync delay wrong"); // R2
endmodule : drc_sync
`default_nettype wire

// File: logic/drc_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module drc_ramp (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [drc_pkg::FREQ_W-1:0] target,
    input  wire logic [drc_pkg::PER_W-1:0]  accelCyc,
    input  wire logic [drc_pkg::PER_W-1:0]  decelCyc,
    input  wire logic                       clear,
    output logic      [drc_pkg::FREQ_W-1:0] freq
);
    import drc_pkg::*;
    typedef struct packed {
        logic [FREQ_W-1:0] freq;
        logic [PER_W-1:0]  cnt;
    } drc_ramp_s;
    drc_ramp_s s;
    drc_ramp_s next_s;
    logic [PER_W-1:0] period;

    always_comb begin
        next_s = s;
        period = (s.freq < target) ? accelCyc : decelCyc;
        if (clear) begin
            next_s = '0; // R9
        end else if (s.freq == target) begin
            next_s.cnt = '0; // R13
        end else if (s.cnt + 1'b1 >= period) begin
            // one unit per tick; tick period carries the ramp time
            next_s.cnt  = '0;
            next_s.freq = (s.freq < target) ? s.freq + 1'b1 : s.freq - 1'b1; // R6 R13
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign freq = s.freq;

    property p_step_one;
        @(posedge clk) disable iff (!rst_n)
        !clear |=> (freq - $past(freq) == 14'h1) || ($past(freq) - freq == 14'h1)
                   || (freq == $past(freq));
    endproperty
    a_step_one: assert property (p_step_one) else $error("ramp step above one unit"); // R6

    property p_hold_target;
        @(posedge clk) disable iff (!rst_n)
        (freq == target && !clear) ##1 (target == $past(target) && !clear) |-> freq == target;
    endproperty
    a_hold_target: assert property (p_hold_target) else $error("ramp left target"); // R13
endmodule : drc_ramp
`default_nettype wire

// File: logic/drc_run_ramp.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] forward and reverse are exclusive; both asserted never yields a run
// [R2] a run starts only on a rising edge of its enable; a source switch onto an enable already high also starts one
// [R3] the controller requests a run by raising forward or reverse
// [R4] after reset: stopped, ready, stop shown, output inhibited
// [R5] setpoint 0 to full scale maps linearly to 0 to 50 Hz
// [R6] output frequency moves only along the accel or decel ramp, default 5 s
// [R7] ramp time is the time for a full-scale frequency change
// [R8] acceleration time comes from a writable setting
// [R9] dropping the active enable inhibits at once and zeroes frequency
// [R10] reverse running shows the frequency negative
// [R11] local source: mode 5 gives reverse/stop/forward, mode 0 forward only
// [R12] aeration: forward on input one, reverse on inputs two and three at fixed frequency
// [R13] ramp steps by a fixed unit per tick and stops exactly at target
module drc_run_ramp #(
    parameter int CYC_PER_MS = drc_pkg::CLK_HZ / drc_pkg::MS_PER_S
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [drc_pkg::ADR_W-1:0]  regAddr,
    input  wire logic [31:0]                regWrData,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic      [31:0]                regRdData,
    input  wire logic                       digitalInputOne,
    input  wire logic                       digitalInputTwo,
    input  wire logic                       digitalInputThree,
    input  wire logic                       selFwdPin,
    input  wire logic                       selRevPin,
    input  wire logic [drc_pkg::SP_W-1:0]   setpointCode,
    output logic                            driveReady,
    output logic                            runInhibit,
    output logic                            dirReverse,
    output logic                            dispStop,
    output logic      [drc_pkg::FREQ_W-1:0] outFreq,
    output logic      [drc_pkg::FREQ_W:0]   dispFreq
);
    import drc_pkg::*;

    typedef struct packed {
        logic              ctrlSrc;
        logic [2:0]        ctrlMode;
        logic              ctrlAer;
        logic [MS_W-1:0]   accelMs;
        logic [MS_W-1:0]   decelMs;
        logic [FREQ_W-1:0] fixedFreq;
        drc_state_e        st;
        logic              prevFwd;
        logic              prevRev;
        logic [31:0]       rdData;
        logic              ready;
        logic              inhibit;
        logic              dirRev;
        logic              stopShown;
        logic [FREQ_W:0]   dispFreq;
    } drc_top_s;

    localparam drc_top_s RST = '{
        ctrlSrc:   SRC_LOCAL,
        ctrlMode:  MODE_RST,
        ctrlAer:   1'b0,
        accelMs:   RAMP_DEF_MS,
        decelMs:   RAMP_DEF_MS,
        fixedFreq: FIXED_DEF,
        st:        DRC_STOP,
        // held-high enables at power-up must not look like an edge
        prevFwd:   1'b1,
        prevRev:   1'b1,
        rdData:    32'h0,
        ready:     1'b0,
        inhibit:   1'b1,
        dirRev:    1'b0,
        stopShown: 1'b1,
        dispFreq:  15'h0
    };

    drc_top_s s;
    drc_top_s next_s;

    logic [PIN_N-1:0]  pinSync;
    logic              inOne;
    logic              inTwo;
    logic              inThree;
    logic              selFwd;
    logic              selRev;
    logic              runForwardCmd;
    logic              runReverseCmd;
    logic              fwdRise;
    logic              revRise;
    logic [25:0]       spScaled;
    logic [FREQ_W-1:0] spTarget;
    logic [FREQ_W-1:0] target;
    logic [35:0]       accelWide;
    logic [35:0]       decelWide;
    logic [PER_W-1:0]  accelCyc;
    logic [PER_W-1:0]  decelCyc;
    logic [FREQ_W-1:0] rampFreq;

    drc_sync #(
        .W(PIN_N)
    ) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  ({selRevPin, selFwdPin, digitalInputThree, digitalInputTwo, digitalInputOne}),
        .pinSync(pinSync)
    );

    assign inOne   = pinSync[0];
    assign inTwo   = pinSync[1];
    assign inThree = pinSync[2];
    assign selFwd  = pinSync[3];
    assign selRev  = pinSync[4];

    // command source selection
    always_comb begin
        if (s.ctrlAer) begin
            runForwardCmd = inOne; // R12
            runReverseCmd = inTwo & inThree; // R12
        end else if (s.ctrlSrc == SRC_LOCAL) begin
            runForwardCmd = selFwd; // R11
            runReverseCmd = (s.ctrlMode == MODE_BOTH) ? selRev : 1'b0; // R11
        end else begin
            runForwardCmd = inOne;
            runReverseCmd = inTwo;
        end
    end

    // edge taken after source mux, so a mode switch onto a source already high reads as a start
    assign fwdRise = runForwardCmd & ~s.prevFwd; // R2
    assign revRise = runReverseCmd & ~s.prevRev; // R2

    // setpoint is from the on-chip converter, same clock
    assign spScaled = (26'(setpointCode) * 26'(FREQ_FULL)) / 26'(SP_FULL); // R5
    assign spTarget = spScaled[FREQ_W-1:0];
    assign target   = (s.ctrlAer && s.st == DRC_REV) ? s.fixedFreq : spTarget; // R12

    // ramp time spans the full 0 to 50 Hz range
    assign accelWide = (36'(s.accelMs) * 36'(CYC_PER_MS)) / 36'(FREQ_FULL); // R7 R8
    assign decelWide = (36'(s.decelMs) * 36'(CYC_PER_MS)) / 36'(FREQ_FULL); // R7
    assign accelCyc  = (accelWide == 36'h0) ? PER_W'(1) : accelWide[PER_W-1:0];
    assign decelCyc  = (decelWide == 36'h0) ? PER_W'(1) : decelWide[PER_W-1:0];

    drc_ramp u_ramp (
        .clk     (clk),
        .rst_n   (rst_n),
        .target  (target),
        .accelCyc(accelCyc),
        .decelCyc(decelCyc),
        .clear   (s.inhibit),
        .freq    (rampFreq)
    );

    always_comb begin
        next_s         = s;
        next_s.prevFwd = runForwardCmd;
        next_s.prevRev = runReverseCmd;
        next_s.ready   = 1'b1; // R4
        next_s.rdData  = 32'h0;

        if (regWr) begin
            unique case (regAddr)
                ADR_CTRL: begin
                    next_s.ctrlSrc  = regWrData[CTRL_SRC_BIT];
                    next_s.ctrlMode = regWrData[CTRL_MODE_LSB +: 3];
                    next_s.ctrlAer  = regWrData[CTRL_AER_BIT];
                end
                ADR_ACCEL: next_s.accelMs = regWrData[MS_W-1:0]; // R8
                ADR_DECEL: next_s.decelMs = regWrData[MS_W-1:0];
                ADR_FIXED: next_s.fixedFreq = regWrData[FREQ_W-1:0];
                default: ;
            endcase
        end

        if (regRd) begin
            unique case (regAddr)
                ADR_CTRL: begin
                    next_s.rdData[CTRL_SRC_BIT]       = s.ctrlSrc;
                    next_s.rdData[CTRL_MODE_LSB +: 3] = s.ctrlMode;
                    next_s.rdData[CTRL_AER_BIT]       = s.ctrlAer;
                end
                ADR_ACCEL:  next_s.rdData[MS_W-1:0] = s.accelMs;
                ADR_DECEL:  next_s.rdData[MS_W-1:0] = s.decelMs;
                ADR_FIXED:  next_s.rdData[FREQ_W-1:0] = s.fixedFreq;
                ADR_STATUS: begin
                    next_s.rdData[ST_READY_BIT] = s.ready;
                    next_s.rdData[ST_RUN_BIT]   = ~s.inhibit;
                    next_s.rdData[ST_REV_BIT]   = s.dirRev;
                end
                ADR_FREQ:   next_s.rdData = {{17{s.dispFreq[FREQ_W]}}, s.dispFreq};
                ADR_TARGET: next_s.rdData[FREQ_W-1:0] = target;
                default:    next_s.rdData = 32'h0;
            endcase
        end

        unique case (s.st)
            DRC_STOP: begin
                // simultaneous requests cancel each other
                if (fwdRise && !runReverseCmd) begin
                    next_s.st = DRC_FWD; // R1 R2
                end else if (revRise && !runForwardCmd) begin
                    next_s.st = DRC_REV; // R1 R2
                end
            end
            DRC_FWD: begin
                if (!runForwardCmd || runReverseCmd) begin
                    next_s.st = DRC_STOP; // R1 R9
                end
            end
            DRC_REV: begin
                if (!runReverseCmd || runForwardCmd) begin
                    next_s.st = DRC_STOP; // R1 R9
                end
            end
            default: next_s.st = DRC_STOP;
        endcase

        next_s.inhibit   = (next_s.st == DRC_STOP); // R4 R9
        next_s.stopShown = (next_s.st == DRC_STOP); // R4
        next_s.dirRev    = (next_s.st == DRC_REV);
        next_s.dispFreq  = (s.st == DRC_REV) ? -{1'b0, rampFreq} : {1'b0, rampFreq}; // R10
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    assign regRdData  = s.rdData;
    assign driveReady = s.ready;
    assign runInhibit = s.inhibit;
    assign dirReverse = s.dirRev;
    assign dispStop   = s.stopShown;
    assign outFreq    = rampFreq;
    assign dispFreq   = s.dispFreq;

    property p_excl;
        @(posedge clk) disable iff (!rst_n)
        (runForwardCmd && runReverseCmd) |=> s.st == DRC_STOP;
    endproperty
    a_excl: assert property (p_excl) else $error("run with both directions"); // R1

    property p_no_level_start;
        @(posedge clk) disable iff (!rst_n)
        (s.st == DRC_STOP && !fwdRise && !revRise) |=> s.st == DRC_STOP;
    endproperty
    a_no_level_start: assert property (p_no_level_start) else $error("start without edge"); // R2

    property p_power_up;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> (s.st == DRC_STOP && runInhibit && dispStop) ##1 driveReady;
    endproperty
    a_power_up: assert property (p_power_up) else $error("not stopped and ready"); // R4

    property p_scale;
        @(posedge clk) disable iff (!rst_n)
        (setpointCode == SP_FULL) |-> spTarget == FREQ_FULL;
    endproperty
    a_scale: assert property (p_scale) else $error("full scale not 50 Hz"); // R5

    property p_ramp_time;
        @(posedge clk) disable iff (!rst_n)
        (s.accelMs == RAMP_DEF_MS) |-> accelCyc == PER_W'(CYC_PER_MS);
    endproperty
    a_ramp_time: assert property (p_ramp_time) else $error("ramp period wrong"); // R7

    property p_accel_cfg;
        @(posedge clk) disable iff (!rst_n)
        (regWr && regAddr == ADR_ACCEL) |=> s.accelMs == $past(regWrData[MS_W-1:0]);
    endproperty
    a_accel_cfg: assert property (p_accel_cfg) else $error("accel setting not taken"); // R8

    property p_kill;
        @(posedge clk) disable iff (!rst_n)
        (s.st == DRC_FWD && !runForwardCmd) |=> (runInhibit && s.st == DRC_STOP) ##1 outFreq == '0;
    endproperty
    a_kill: assert property (p_kill) else $error("no immediate stop"); // R9

    property p_neg_disp;
        @(posedge clk) disable iff (!rst_n)
        (s.st == DRC_REV && rampFreq != '0) |=> dispFreq == -{1'b0, $past(rampFreq)};
    endproperty
    a_neg_disp: assert property (p_neg_disp) else $error("reverse not negative"); // R10

    property p_fwd_only;
        @(posedge clk) disable iff (!rst_n)
        (s.st == DRC_STOP && !s.ctrlAer && s.ctrlSrc == SRC_LOCAL && s.ctrlMode == MODE_FWD_ONLY)
            |=> s.st != DRC_REV;
    endproperty
    a_fwd_only: assert property (p_fwd_only) else $error("reverse in forward-only mode"); // R11

    property p_aer_fixed;
        @(posedge clk) disable iff (!rst_n)
        (s.ctrlAer && s.st == DRC_REV) |-> target == s.fixedFreq;
    endproperty
    a_aer_fixed: assert property (p_aer_fixed) else $error("aeration reverse not fixed"); // R12

    property p_cv_fwd;
        @(posedge clk) disable iff (!rst_n) s.st == DRC_STOP ##1 s.st == DRC_FWD;
    endproperty
    c_cv_fwd: cover property (p_cv_fwd);

    property p_cv_rev;
        @(posedge clk) disable iff (!rst_n) s.st == DRC_STOP ##1 s.st == DRC_REV;
    endproperty
    c_cv_rev: cover property (p_cv_rev);

    property p_cv_full;
        @(posedge clk) disable iff (!rst_n) rampFreq == FREQ_FULL;
    endproperty
    c_cv_full: cover property (p_cv_full);

    property p_cv_kill;
        @(posedge clk) disable iff (!rst_n) rampFreq != '0 ##1 runInhibit;
    endproperty
    c_cv_kill: cover property (p_cv_kill);
endmodule : drc_run_ramp
`default_nettype wire

// File: bench/drc_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module drc_field_model (
    input  wire logic                     cwReq,
    input  wire logic                     ccwReq,
    input  wire logic                     useTerm,
    input  wire logic                     jumper,
    input  wire logic [drc_pkg::SP_W-1:0] potCode,
    output logic                          digitalInputOne,
    output logic                          digitalInputTwo,
    output logic                          digitalInputThree,
    output logic                          selFwdPin,
    output logic                          selRevPin,
    output logic      [drc_pkg::SP_W-1:0] setpointCode
);
    import drc_pkg::*;
    // a contact raises only the input of the wired source, the other stays open
    assign digitalInputOne   = cwReq & useTerm;
    assign digitalInputTwo   = ccwReq & useTerm;
    // without the jumper input three stays open
    assign digitalInputThree = jumper & digitalInputTwo;
    assign selFwdPin         = cwReq & ~useTerm;
    assign selRevPin         = ccwReq & ~useTerm;
    assign setpointCode      = potCode;
endmodule : drc_field_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import drc_pkg::*;
    logic        clk, rst_n, regWr, regRd, cwReq, ccwReq, useTerm, jumper, rdLate;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, rng;
    logic [11:0] potCode, spCode;
    logic        inOne, inTwo, inThree, selF, selR;
    logic        driveReady, runInhibit, dirReverse, dispStop;
    logic [13:0] outFreq;
    logic [14:0] dispFreq;
    logic [31:0] expQ[$];
    int          errTotal, checkCount, i;
    logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
    logic [31:0] rv[7] = '{32'h50, 32'h1388, 32'h1388, 32'h5dc, 32'h1, 32'h0, 32'h0};

    drc_field_model drc_field_model_inst (.cwReq(cwReq), .ccwReq(ccwReq), .useTerm(useTerm),
        .jumper(jumper), .potCode(potCode), .digitalInputOne(inOne), .digitalInputTwo(inTwo),
        .digitalInputThree(inThree), .selFwdPin(selF), .selRevPin(selR), .setpointCode(spCode));
    // short ms scale keeps full-scale ramps within a few thousand cycles
    drc_run_ramp #(.CYC_PER_MS(20)) drc_run_ramp_inst (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .digitalInputOne(inOne), .digitalInputTwo(inTwo),
        .digitalInputThree(inThree), .selFwdPin(selF), .selRevPin(selR),
        .setpointCode(spCode), .driveReady(driveReady), .runInhibit(runInhibit),
        .dirReverse(dirReverse), .dispStop(dispStop), .outFreq(outFreq), .dispFreq(dispFreq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [31:0] tgtOf(input logic [11:0] s);
        return (32'(s) * 32'd5000) / 32'd4095;
    endfunction : tgtOf

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrapUp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd

    // read data are valid only in the cycle after the strobe
    always @(posedge clk) begin
        rdLate <= regRd;
        if (rdLate === 1'b1 && expQ.size() > 0)
            chk("regRdData", regRdData, expQ.pop_front());
    end

    task automatic waitInh(input logic lvl, output int c);
        c = 0;
        while (runInhibit !== lvl) begin
            @(posedge clk);
            #1;
            c++;
            if (c > 12) begin
                chk("runInhibitWait", runInhibit, lvl);
                wrapUp();
            end
        end
    endtask : waitInh

    task automatic go(input logic cw, input logic ccw);
        int c;
        @(posedge clk);
        cwReq  <= cw;
        ccwReq <= ccw;
        waitInh(1'b0, c);
        chk("startLatency", c, 3);
        chk("dispStop", dispStop, 1'b0);
        chk("dirReverse", dirReverse, ccw);
    endtask : go

    task automatic halt(input logic cw, input logic ccw);
        int c;
        @(posedge clk);
        cwReq  <= cw;
        ccwReq <= ccw;
        waitInh(1'b1, c);
        chk("stopLatency", c, 3);
        @(posedge clk);
        #1;
        chk("outFreqCut", outFreq, 14'h0);
    endtask : halt

    task automatic noRun(input logic cw, input logic ccw);
        @(posedge clk);
        cwReq  <= cw;
        ccwReq <= ccw;
        repeat (10) @(posedge clk);
        #1;
        chk("noStart", runInhibit, 1'b1);
    endtask : noRun

    // step size and total time are checked, tolerance of one period plus latency
    task automatic ramp(input logic [13:0] tgt, input int per);
        int c, n, bad, d;
        logic [13:0] p;
        c   = 0;
        bad = 0;
        p   = outFreq;
        n   = (int'(p) > int'(tgt)) ? int'(p) - int'(tgt) : int'(tgt) - int'(p);
        while (outFreq !== tgt) begin
            @(posedge clk);
            #1;
            c++;
            d = int'(outFreq) - int'(p);
            if (d > 1 || d < -1)
                bad++;
            p = outFreq;
            if (c > 2 * n * per + 50) begin
                chk("rampEnd", outFreq, tgt);
                wrapUp();
            end
        end
        chk("rampStep", bad, 0);
        chk("rampTime", (c >= n * per - per - 3) && (c <= n * per + per + 3), 1);
        repeat (5) @(posedge clk);
        #1;
        chk("rampHold", outFreq, tgt);
    endtask : ramp

    initial begin
        rst_n     = 1'b0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        regAddr   = 8'h00;
        regWrData = 32'h0;
        cwReq     = 1'b1;
        ccwReq    = 1'b0;
        useTerm   = 1'b0;
        jumper    = 1'b0;
        potCode   = 12'h800;
        rng       = 32'd48030;
        errTotal  = 0;
        checkCount = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("readyFirst", driveReady, 1'b0);
        chk("inhibitReset", runInhibit, 1'b1);
        chk("dispStopReset", dispStop, 1'b1);
        @(posedge clk);
        #1;
        chk("readySecond", driveReady, 1'b1);
        for (i = 0; i < 7; i++)
            rd(ra[i], rv[i]);
        wr(ADR_STATUS, 32'hff);
        rd(ADR_STATUS, 32'h1);
        noRun(1'b1, 1'b0);
        $display("test reset done");

        cwReq <= 1'b0;
        wr(ADR_ACCEL, 32'd250);
        wr(ADR_DECEL, 32'd500);
        useTerm <= 1'b1;
        wr(ADR_CTRL, 32'h51);
        repeat (3) @(posedge clk);
        go(1'b1, 1'b0);
        ramp(14'd2500, 1);
        rd(ADR_TARGET, 32'd2500);
        rd(ADR_STATUS, 32'h3);
        rd(ADR_FREQ, 32'd2500);
        halt(1'b1, 1'b1);
        noRun(1'b0, 1'b1);
        $display("test accel and interlock done");

        potCode <= 12'h0a0;
        noRun(1'b0, 1'b0);
        go(1'b0, 1'b1);
        ramp(14'd195, 1);
        @(posedge clk);
        #1;
        chk("dispFreqNeg", dispFreq, 15'h7f3d);
        rd(ADR_STATUS, 32'h7);
        rd(ADR_FREQ, 32'hffffff3d);
        potCode <= 12'h000;
        ramp(14'd0, 2);
        potCode <= 12'h800;
        repeat (50) @(posedge clk);
        halt(1'b0, 1'b0);
        $display("test reverse and decel done");

        wr(ADR_ACCEL, 32'd500);
        potCode <= 12'h0a0;
        go(1'b1, 1'b0);
        ramp(14'd195, 2);
        halt(1'b0, 1'b0);
        $display("test accel setting done");

        useTerm <= 1'b0;
        wr(ADR_CTRL, 32'h00);
        noRun(1'b0, 1'b1);
        noRun(1'b0, 1'b0);
        go(1'b1, 1'b0);
        halt(1'b0, 1'b0);
        wr(ADR_CTRL, 32'h50);
        go(1'b0, 1'b1);
        halt(1'b0, 1'b0);
        $display("test selector modes done");

        useTerm <= 1'b1;
        wr(ADR_FIXED, 32'd200);
        wr(ADR_CTRL, 32'h151);
        noRun(1'b0, 1'b1);
        noRun(1'b0, 1'b0);
        jumper <= 1'b1;
        go(1'b0, 1'b1);
        ramp(14'd200, 2);
        rd(ADR_TARGET, 32'd200);
        halt(1'b0, 1'b0);
        go(1'b1, 1'b0);
        ramp(14'd195, 2);
        halt(1'b0, 1'b0);
        $display("test aeration done");

        wr(ADR_CTRL, 32'h51);
        go(1'b1, 1'b0);
        for (i = 0; i < 6; i++) begin
            rng = xs(rng);
            potCode <= rng[11:0];
            repeat (3) @(posedge clk);
            rd(ADR_TARGET, tgtOf(rng[11:0]));
        end
        potCode <= SP_FULL;
        repeat (3) @(posedge clk);
        rd(ADR_TARGET, 32'(FREQ_FULL));
        halt(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        $display("test random setpoints done");
        wrapUp();
    end
endmodule : tb
`default_nettype wire
